// *** src/ccasc_decide.sv ***
// Combines carrier-sense and energy observations into an idle/busy verdict.
// Assumes the observations were gathered over the whole assessment window.
`timescale 1ns/100ps
module ccasc_decide
  import ccasc_pkg::*;
(
  input  wire logic       [1:0] method,
  input  wire logic             carrierSeen,
  input  wire logic             energySeen,
  output logic                  channelIdle
);
  logic busy;

  // Busy decision per selected method
  always_comb begin
    busy = 1'b0;
    case (ccasc_method_e'(method))
      CS_OR_ED:  busy = carrierSeen | energySeen;
      ED_ONLY:   busy = energySeen;
      CS_ONLY:   busy = carrierSeen;
      CS_AND_ED: busy = carrierSeen & energySeen;
      default:   busy = 1'b0;
    endcase
  end

  // Idle reads as one, busy as zero
  assign channelIdle = ~busy;
endmodule : ccasc_decide

// *** src/ccasc_pkg.sv ***
// Shared constants, register layouts and state codes for the channel assessment registers.
// Assumes a single 100 MHz clock domain and byte-wide register accesses.
package ccasc_pkg;

  // Register addresses on the host register port
  localparam logic [7:0] STATUS_ADDR  = 8'h01;
  localparam logic [7:0] CONTROL_ADDR = 8'h08;

  // Reset values of the control fields
  localparam logic [1:0] METHOD_RESET  = 2'h1;
  localparam logic [4:0] CHANNEL_RESET = 5'h0B;

  // Reserved status bit reads as this value
  localparam logic RSVD_READ = 1'b0;

  // Assessment window and clock rate
  localparam int WINDOW_US     = 128;
  localparam int CLK_MHZ       = 100;
  localparam int WINDOW_CYCLES = WINDOW_US * CLK_MHZ;

  // Assessment method select encoding
  typedef enum logic [1:0] {
    CS_OR_ED  = 2'b00,
    ED_ONLY   = 2'b01,
    CS_ONLY   = 2'b10,
    CS_AND_ED = 2'b11
  } ccasc_method_e;

  // Measurement sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_MEASURE = 2'b01,
    ST_FINISH  = 2'b10
  } ccasc_state_e;

  // Status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       done;
    logic       idle;
    logic       rsvd;
    logic [4:0] trxState;
  } ccasc_status_s;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       trigger;
    logic [1:0] method;
    logic [4:0] channel;
  } ccasc_control_s;

  // One register access request from the host port
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } ccasc_req_s;

endpackage : ccasc_pkg

// *** src/ccasc_regs.sv ***
// Channel assessment status and control registers with the measurement sequencer.
// Assumes register requests, transceiver state and radio observations are synchronous to ref_clk.
// Assumes host strobes last one cycle and read data is taken in the cycle after the strobe.
`timescale 1ns/100ps
module ccasc_regs
  import ccasc_pkg::*;
#(
  parameter int WINDOW_LEN = WINDOW_CYCLES
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             clkEn,
  input  wire ccasc_req_s       hostReq,
  output logic       [7:0]      regRdData,
  output logic                  regRdValid,
  input  wire logic  [4:0]      trxState,
  input  wire logic             rxListen,
  input  wire logic             rxBusy,
  input  wire logic             carrierSense,
  input  wire logic             energyAbove,
  output logic       [4:0]      channel,
  output logic       [1:0]      assessMethod,
  output logic                  assessCompleteIrq,
  output logic                  measuring
);

  // Address match used by both read and write decode
  // Exact match only: the register port has no aliases or mirrored offsets
  function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] target);
    addrHit = (addr == target);
  endfunction : addrHit

  // Write strobe aimed at the control register
  // Shared by the trigger decode and the method and channel update
  function automatic logic ctrlWrite(input ccasc_req_s req);
    ctrlWrite = req.wrEn && addrHit(req.addr, CONTROL_ADDR);
  endfunction : ctrlWrite

  // Value returned after reset and for unmapped reads
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  ccasc_state_e   state;
  ccasc_state_e   next_state;
  ccasc_control_s wrCtrl;
  ccasc_status_s  statusView;
  ccasc_control_s controlView;

  // Status flags and window observations
  logic doneFlag;
  logic idleFlag;
  logic carrierSeen;
  logic energySeen;
  logic skipMeasure;
  logic pendTrig;

  // Trigger decode
  logic wrTrig;
  logic trigNow;
  logic inRx;
  logic takeTrig;

  // Timer handshake and verdict
  logic startTimer;
  logic abortTimer;
  logic winExpire;
  logic winRunning;
  logic decidedIdle;
  logic finishEvt;

  // Write data viewed as control fields
  // The trigger bit is decoded here and never stored as a field
  assign wrCtrl = ccasc_control_s'(hostReq.wrData);

  // A write of one to the trigger bit requests a measurement
  // Writes with the trigger low only change method and channel
  assign wrTrig = clkEn && ctrlWrite(hostReq) && wrCtrl.trigger;

  // Triggers seen during the finish cycle are replayed afterwards
  // Replaying keeps a host write from being lost when it meets a completion
  assign trigNow = wrTrig || pendTrig;

  // Either receive state permits a real measurement
  // Both receive states share one fixed window length
  assign inRx = rxListen || rxBusy;

  // Trigger is taken in idle and measure states only
  // In the finish cycle it would clear done before software could see it,
  // and on the expiry edge it would race the verdict, so both cases wait
  assign takeTrig   = trigNow && (state != ST_FINISH) && !(state == ST_MEASURE && winExpire);
  assign startTimer = takeTrig && inRx;
  assign abortTimer = takeTrig && !inRx;
  assign finishEvt  = clkEn && (state == ST_FINISH);

  // Window timer for the receive-state observation
  // Start and expiry never meet: takeTrig is held off in the expiry cycle
  ccasc_win_timer #(
    .CYCLES (WINDOW_LEN)
  ) u_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clkEn   (clkEn),
    .start   (startTimer),
    .abort   (abortTimer),
    .expire  (winExpire),
    .running (winRunning)
  );

  // Verdict from the accumulated observations
  // The method is read live, so a write during the window changes the verdict
  ccasc_decide u_decide (
    .method      (assessMethod),
    .carrierSeen (carrierSeen),
    .energySeen  (energySeen),
    .channelIdle (decidedIdle)
  );

  // Next-state decode for the sequencer
  // A retrigger while measuring restarts the window unless the radio left receive
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (takeTrig) begin
          next_state = inRx ? ST_MEASURE : ST_FINISH;
        end
      end
      ST_MEASURE: begin
        if (winExpire) begin
          next_state = ST_FINISH;
        end else if (takeTrig && !inRx) begin
          next_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  // Clock enable low freezes the sequencer and the window together
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // Remember whether this completion follows a skipped measurement
  // Sampled when the trigger is taken, since the receive state may change later
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      skipMeasure <= 1'b0;
    end else if (clkEn) begin
      if (takeTrig) begin
        skipMeasure <= !inRx;
      end
    end
  end

  // Hold a trigger that lands in the finish cycle or on window expiry
  // Only one trigger is remembered; further ones in the same gap merge into it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pendTrig <= 1'b0;
    end else if (clkEn) begin
      if (trigNow && !takeTrig) begin
        pendTrig <= 1'b1;
      end else if (takeTrig) begin
        pendTrig <= 1'b0;
      end
    end
  end

  // Gather carrier and energy observations across the window
  // Sticky OR: one active cycle anywhere in the window keeps that observation set until the next trigger
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      carrierSeen <= 1'b0;
      energySeen  <= 1'b0;
    end else if (clkEn) begin
      if (takeTrig) begin
        carrierSeen <= 1'b0;
        energySeen  <= 1'b0;
      end else if (winRunning) begin
        carrierSeen <= carrierSeen | carrierSense;
        energySeen  <= energySeen | energyAbove;
      end
    end
  end

  // Done flag: cleared on trigger, set on completion, set wins
  // A trigger is never taken in the finish cycle, so the two never collide
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      doneFlag <= 1'b0;
    end else if (clkEn) begin
      if (finishEvt) begin
        doneFlag <= 1'b1;
      end else if (takeTrig) begin
        doneFlag <= 1'b0;
      end
    end
  end

  // Idle result: cleared on trigger, loaded with the verdict on completion
  // A skipped measurement reports busy, so a stale idle verdict is never shown
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      idleFlag <= 1'b0;
    end else if (clkEn) begin
      if (finishEvt) begin
        idleFlag <= skipMeasure ? 1'b0 : decidedIdle;
      end else if (takeTrig) begin
        idleFlag <= 1'b0;
      end
    end
  end

  // Completion interrupt event, one cycle per finished assessment
  // Registered so the pulse lines up with the done flag becoming visible
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      assessCompleteIrq <= 1'b0;
    end else if (clkEn) begin
      assessCompleteIrq <= finishEvt;
    end
  end

  // Busy indication while an assessment is outstanding
  // Registered from the next state so it tracks the sequencer edge for edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      measuring <= 1'b0;
    end else if (clkEn) begin
      measuring <= (next_state != ST_IDLE);
    end
  end

  // Method and channel fields, written through the control register
  // The trigger bit is not stored; only method and channel persist
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      assessMethod <= METHOD_RESET;
      channel      <= CHANNEL_RESET;
    end else if (clkEn) begin
      if (ctrlWrite(hostReq)) begin
        assessMethod <= wrCtrl.method;
        channel      <= wrCtrl.channel;
      end
    end
  end

  // Read views of both registers
  // Status bits 4..0 pass the transceiver state through live, unlatched
  always_comb begin
    statusView.done     = doneFlag;
    statusView.idle     = idleFlag;
    statusView.rsvd     = RSVD_READ;
    statusView.trxState = trxState;
    controlView.trigger = 1'b0;
    controlView.method  = assessMethod;
    controlView.channel = channel;
  end

  // Registered read data, zero for unmapped addresses
  // Data holds between reads so a slow host may sample it late
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regRdData  <= UNMAPPED_READ;
      regRdValid <= 1'b0;
    end else if (clkEn) begin
      regRdValid <= hostReq.rdEn;
      if (hostReq.rdEn) begin
        if (addrHit(hostReq.addr, STATUS_ADDR)) begin
          regRdData <= statusView;
        end else if (addrHit(hostReq.addr, CONTROL_ADDR)) begin
          regRdData <= controlView;
        end else begin
          regRdData <= UNMAPPED_READ;
        end
      end
    end
  end

endmodule : ccasc_regs

// *** src/ccasc_win_timer.sv ***
// Down-counter that times one assessment window and pulses on expiry.
// Assumes start and enable are synchronous to ref_clk.
`timescale 1ns/100ps
module ccasc_win_timer #(
  parameter int CYCLES = 12800
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic clkEn,
  input  wire logic start,
  input  wire logic abort,
  output logic      expire,
  output logic      running
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] count;

  // Load on start, count down while running, stop at zero or on abort
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count   <= '0;
      running <= 1'b0;
    end else if (clkEn) begin
      if (start) begin
        count   <= LAST;
        running <= 1'b1;
      end else if (abort) begin
        running <= 1'b0;
      end else if (running) begin
        if (count == ZERO) begin
          running <= 1'b0;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

  // Expiry pulse in the last counted cycle
  // Independent of start and abort so no combinational path runs back to the caller;
  // the caller must not raise start or abort in the expiry cycle
  assign expire = running && (count == ZERO) && clkEn;
endmodule : ccasc_win_timer

// *** test/ccasc_regs_monitor.sv ***
// Port-level checks of the channel assessment registers and sequencer.
// Assumes it is bound to ccasc_regs and that clkEn is held high while triggers run.
`timescale 1ns/100ps
module ccasc_regs_monitor
  import ccasc_pkg::*;
#(
  parameter int WINDOW_LEN = 8
) (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       clkEn,
  input wire ccasc_req_s hostReq,
  input wire logic [7:0] regRdData,
  input wire logic       regRdValid,
  input wire logic [4:0] trxState,
  input wire logic       rxListen,
  input wire logic       rxBusy,
  input wire logic [4:0] channel,
  input wire logic [1:0] assessMethod,
  input wire logic       assessCompleteIrq,
  input wire logic       measuring
);
  localparam int IRQ_LAT = WINDOW_LEN + 2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Decoded request kinds
  logic rdSt, rdCt, rdOther, wrCt, trigIdle;
  assign rdSt     = clkEn && hostReq.rdEn && hostReq.addr == STATUS_ADDR;
  assign rdCt     = clkEn && hostReq.rdEn && !hostReq.wrEn && hostReq.addr == CONTROL_ADDR;
  assign rdOther  = clkEn && hostReq.rdEn && hostReq.addr != STATUS_ADDR && hostReq.addr != CONTROL_ADDR;
  assign wrCt     = clkEn && hostReq.wrEn && hostReq.addr == CONTROL_ADDR;
  assign trigIdle = wrCt && hostReq.wrData[7] && !measuring;
  property p_rd_valid; clkEn && hostReq.rdEn |=> regRdValid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_st_read; rdSt |=> !regRdData[5] && regRdData[4:0] == $past(trxState); endproperty
  a_st_read: assert property (p_st_read) else $error("status read wrong");
  property p_done_low; rdSt && measuring |=> !regRdData[7] && !regRdData[6]; endproperty
  a_done_low: assert property (p_done_low) else $error("done set while measuring");
  property p_ct_read; rdCt |=> regRdData == {1'b0, $past(assessMethod), $past(channel)}; endproperty
  a_ct_read: assert property (p_ct_read) else $error("control read wrong");
  property p_ct_write;
    wrCt |=> channel == $past(hostReq.wrData[4:0]) && assessMethod == $past(hostReq.wrData[6:5]);
  endproperty
  a_ct_write: assert property (p_ct_write) else $error("control write lost");
  property p_unmapped; rdOther |=> regRdData == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_no_rx; trigIdle && !(rxListen || rxBusy) |-> ##2 assessCompleteIrq; endproperty
  a_no_rx: assert property (p_no_rx) else $error("skipped assessment not completed");
  property p_rx_win; trigIdle && (rxListen || rxBusy) |-> ##IRQ_LAT assessCompleteIrq && $past(measuring); endproperty
  a_rx_win: assert property (p_rx_win) else $error("window length wrong");
  property p_irq_end; $fell(measuring) |-> assessCompleteIrq ##1 !assessCompleteIrq; endproperty
  a_irq_end: assert property (p_irq_end) else $error("completion event wrong");
  property p_start; trigIdle |=> measuring; endproperty
  a_start: assert property (p_start) else $error("trigger not taken");
  c_rx: cover property (trigIdle && rxListen);
  c_busy: cover property (trigIdle && rxBusy);
  c_norx: cover property (trigIdle && !rxListen && !rxBusy);
endmodule : ccasc_regs_monitor
bind ccasc_regs ccasc_regs_monitor #(.WINDOW_LEN(WINDOW_LEN)) i_ccasc_regs_monitor (
  .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .hostReq(hostReq), .regRdData(regRdData),
  .regRdValid(regRdValid), .trxState(trxState), .rxListen(rxListen), .rxBusy(rxBusy),
  .channel(channel), .assessMethod(assessMethod), .assessCompleteIrq(assessCompleteIrq),
  .measuring(measuring));

// *** test/tb.sv ***
// Self-checking bench for the channel assessment registers.
// Assumes a 100 MHz ref_clk and a shortened window of WLEN cycles.
`timescale 1ns/100ps
module tb
  import ccasc_pkg::*;
;
  localparam int WLEN = 8;
  logic       ref_clk = 1'b0;
  logic       srst    = 1'b1;
  logic       clkEn   = 1'b1;
  ccasc_req_s hostReq = '0;
  logic [4:0] trxState = 5'h00;
  logic       rxListen = 1'b0, rxBusy = 1'b0, carrierSense = 1'b0, energyAbove = 1'b0;
  logic [7:0] regRdData;
  logic       regRdValid, assessCompleteIrq, measuring;
  logic [4:0] channel;
  logic [1:0] assessMethod;
  int         errors = 0, checks = 0;
  logic [1:0] m;
  logic [4:0] ch;
  logic       cs, ed;
  ccasc_regs #(.WINDOW_LEN(WLEN)) i_ccasc_regs (
    .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .hostReq(hostReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .trxState(trxState), .rxListen(rxListen), .rxBusy(rxBusy),
    .carrierSense(carrierSense), .energyAbove(energyAbove), .channel(channel),
    .assessMethod(assessMethod), .assessCompleteIrq(assessCompleteIrq), .measuring(measuring));
  // Clock generator
  always #5 ref_clk = ~ref_clk;
  // Expected idle verdict for a method and steady observations
  function automatic logic exp_idle(input logic [1:0] md, input logic c, input logic e);
    case (md)
      2'h0: exp_idle = !(c | e);
      2'h1: exp_idle = !e;
      2'h2: exp_idle = !c;
      default: exp_idle = !(c & e);
    endcase
  endfunction : exp_idle
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // One write strobe, taken at the second edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) hostReq <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk) hostReq <= '0;
    #1;
  endtask : wr
  // One read strobe, answer checked in the cycle after it
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk) hostReq <= {1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) hostReq <= '0;
    #1;
    check({7'h00, regRdValid}, 8'h01);
    check(regRdData, exp);
  endtask : rd_chk
  // Count edges until the completion event, starting from n0
  task automatic wait_irq(input int n0, input int exp);
    int n;
    n = n0;
    while (assessCompleteIrq !== 1'b1 && n < 60) begin
      @(posedge ref_clk) #1;
      n++;
    end
    check(8'(n), 8'(exp));
  endtask : wait_irq
  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    void'($urandom(22));
    repeat (3) @(posedge ref_clk);
    trxState <= 5'($urandom);
    @(posedge ref_clk);
    srst <= 1'b0;
    rd_chk(STATUS_ADDR, {3'b000, trxState});
    rd_chk(CONTROL_ADDR, {1'b0, 2'h1, 5'h0B});
    wr(STATUS_ADDR, 8'hFF);
    rd_chk(STATUS_ADDR, {3'b000, trxState});
    rd_chk(8'h3C, 8'h00);
    for (int k = 0; k < 4; k++) begin
      m = 2'($urandom);
      ch = (k == 0) ? 5'h1F : 5'($urandom);
      wr(CONTROL_ADDR, {1'b0, m, ch});
      check({1'b0, assessMethod, channel}, {1'b0, m, ch});
      rd_chk(CONTROL_ADDR, {1'b0, m, ch});
    end
    @(posedge ref_clk) clkEn <= 1'b0;
    wr(CONTROL_ADDR, {1'b1, ~m, ~ch});
    check({1'b0, assessMethod, channel}, {1'b0, m, ch});
    check({7'h00, measuring}, 8'h00);
    @(posedge ref_clk) clkEn <= 1'b1;
    wr(CONTROL_ADDR, {1'b1, m, ch});
    wait_irq(0, 1);
    rd_chk(STATUS_ADDR, {3'b100, trxState});
    for (int k = 0; k < 8; k++) begin
      m = 2'(k);
      ch = 5'($urandom);
      cs = 1'($urandom);
      ed = (k == 7) ? !cs : 1'($urandom);
      @(posedge ref_clk);
      trxState <= 5'($urandom);
      rxListen <= (k < 4);
      rxBusy <= (k >= 4);
      carrierSense <= cs;
      energyAbove <= ed;
      wr(CONTROL_ADDR, {1'b1, m, ch});
      check({7'h00, measuring}, 8'h01);
      rd_chk(STATUS_ADDR, {3'b000, trxState});
      wait_irq(2, WLEN + 1);
      check({7'h00, measuring}, 8'h00);
      rd_chk(STATUS_ADDR, {1'b1, exp_idle(m, cs, ed), 1'b0, trxState});
      rd_chk(CONTROL_ADDR, {1'b0, m, ch});
    end
    finish_test();
  end
endmodule : tb
